// *** hdl/pin_triggered_timer.sv ***
// 16-bit pin triggered timer: trigger timer, event count, window, pulse capture.
// Assumes control inputs come from logic on ref_clk; the pin is asynchronous.
//
// Operation
// - Trigger timer idles until the chosen pin edge, then counts source ticks.
// - Stop option set: compare match clears, halts and raises the interrupt.
// - Stop option set: opposite edge before match clears and halts, no interrupt.
// - After halting, the next trigger edge restarts counting from zero.
// - Stop option clear: match halts and interrupts; other edges ignored meanwhile.
// - Pin pulses of 4 fc or less rejected; 12 fc accepted; filter bypass option.
// - Event counter increments on each chosen pin edge.
// - Event match checked at the opposite edge: interrupt, clear, keep counting.
// - Auto capture copies the counter to register B every source tick, except in pulse mode.
// - Window mode counts source ticks gated by pin level; match interrupts, clears.
// - Pulse mode starts at the trigger edge; capture mode picks single or double.
// - Single capture: opposite edge captures, interrupts, sets the counter to one; waits for trigger.
// - Double capture: capture at both edges; trigger edge also clears, keeps counting.
// - Single capture leaves the counter at one until the first source tick after the next trigger edge.
// - New compare value applies at the first source tick after the upper byte.
// - Stop power mode entry forces the start field to zero and halts.
`timescale 1ns/100ps
`default_nettype none

module pin_triggered_timer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic timer_input_pin,
    input wire logic filter_off,
    input wire logic [1:0] operating_mode_select,
    input wire logic [1:0] source_clock_select,
    input wire logic trigger_stop_option,
    input wire logic auto_capture_bit,
    input wire logic capture_mode_bit,
    input wire logic start_wr,
    input wire logic [1:0] start_wr_data,
    input wire logic stop_mode_entry,
    input wire logic compare_wr_lo,
    input wire logic compare_wr_hi,
    input wire logic [7:0] compare_wr_data,
    output logic [1:0] start_control_field,
    output logic [15:0] compare_reg_a,
    output logic [15:0] capture_reg_b,
    output logic [15:0] counter_value,
    output logic counting,
    output logic timer_irq
);

    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic [10:0] prescale;
    logic src_tick;
    logic [7:0] lo_buf;
    logic [7:0] hi_buf;
    logic load_pending;
    logic trig;
    logic opp;
    logic edge_start;
    logic is_cmd;
    logic is_ext;
    logic is_evt;
    logic is_win;
    logic is_pw;
    logic match;
    logic [15:0] count_inc;

    // ========================================================
    // Pin filter
    // ========================================================
    pin_input_filter u_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(timer_input_pin),
        .bypass(filter_off),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ========================================================
    // Mode decode
    // ========================================================
    assign edge_start = start_control_field[1];
    assign trig = (start_control_field == timer_pkg::START_FALL) ? pin_fall : pin_rise;
    assign opp = (start_control_field == timer_pkg::START_FALL) ? pin_rise : pin_fall;
    assign is_cmd = operating_mode_select == timer_pkg::MODE_TIMER
        && start_control_field == timer_pkg::START_CMD;
    assign is_ext = operating_mode_select == timer_pkg::MODE_TIMER && edge_start
        && source_clock_select != timer_pkg::CLK_EXT;
    assign is_evt = operating_mode_select == timer_pkg::MODE_TIMER && edge_start
        && source_clock_select == timer_pkg::CLK_EXT;
    assign is_win = operating_mode_select == timer_pkg::MODE_WINDOW && edge_start;
    assign is_pw = operating_mode_select == timer_pkg::MODE_PULSE && edge_start;
    assign match = counter_value == compare_reg_a;
    assign count_inc = counter_value + 16'h0001;

    // ========================================================
    // Source clock enable
    // ========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prescale <= 11'h000;
        end else begin
            prescale <= prescale + 11'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            src_tick <= 1'b0;
        end else begin
            case (source_clock_select)
                timer_pkg::CLK_DIV11: src_tick <= prescale == timer_pkg::PRE_DIV11;
                timer_pkg::CLK_DIV7: src_tick <= (prescale & timer_pkg::PRE_DIV7)
                    == timer_pkg::PRE_DIV7;
                timer_pkg::CLK_DIV3: src_tick <= (prescale & timer_pkg::PRE_DIV3)
                    == timer_pkg::PRE_DIV3;
                default: src_tick <= 1'b0;
            endcase
        end
    end

    // ========================================================
    // Start control, cleared on stop power mode
    // ========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            start_control_field <= timer_pkg::START_STOP;
        end else if (stop_mode_entry) begin
            start_control_field <= timer_pkg::START_STOP;
        end else if (start_wr) begin
            start_control_field <= start_wr_data;
        end
    end

    // ========================================================
    // Compare register, two byte shift load
    // ========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lo_buf <= timer_pkg::COMPARE_RESET[7:0];
            hi_buf <= timer_pkg::COMPARE_RESET[15:8];
            load_pending <= 1'b0;
            compare_reg_a <= timer_pkg::COMPARE_RESET;
        end else begin
            if (compare_wr_lo) begin
                lo_buf <= compare_wr_data;
            end
            if (compare_wr_hi) begin
                hi_buf <= compare_wr_data;
                load_pending <= 1'b1;
            end else if (load_pending && (src_tick || (is_evt && trig))) begin
                load_pending <= 1'b0;
                compare_reg_a <= {hi_buf, lo_buf};
            end
        end
    end

    // ========================================================
    // Counter, run state and interrupt
    // ========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            counter_value <= timer_pkg::COUNT_RESET;
            counting <= 1'b0;
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= 1'b0;
            if (start_control_field == timer_pkg::START_STOP || stop_mode_entry) begin
                counter_value <= timer_pkg::COUNT_RESET;
                counting <= 1'b0;
            end else if (is_cmd) begin
                counting <= 1'b1;
                if (src_tick) begin
                    counter_value <= match ? timer_pkg::COUNT_RESET : count_inc;
                    timer_irq <= match;
                end
            end else if (is_ext) begin
                if (!counting) begin
                    if (trig) begin
                        counting <= 1'b1;
                        counter_value <= timer_pkg::COUNT_RESET;
                    end
                end else if (trigger_stop_option && opp) begin
                    counting <= 1'b0;
                    counter_value <= timer_pkg::COUNT_RESET;
                end else if (src_tick) begin
                    if (match) begin
                        counting <= 1'b0;
                        counter_value <= timer_pkg::COUNT_RESET;
                        timer_irq <= 1'b1;
                    end else begin
                        counter_value <= count_inc;
                    end
                end
            end else if (is_evt) begin
                counting <= 1'b1;
                if (trig) begin
                    counter_value <= count_inc;
                end else if (opp && match) begin
                    counter_value <= timer_pkg::COUNT_RESET;
                    timer_irq <= 1'b1;
                end
            end else if (is_win) begin
                counting <= 1'b1;
                if (src_tick && pin_level == !start_control_field[0]) begin
                    counter_value <= match ? timer_pkg::COUNT_RESET : count_inc;
                    timer_irq <= match;
                end
            end else if (is_pw) begin
                if (!counting) begin
                    if (trig) begin
                        counting <= 1'b1;
                    end
                end else if (opp) begin
                    timer_irq <= 1'b1;
                    if (capture_mode_bit) begin
                        counting <= 1'b0;
                        counter_value <= timer_pkg::COUNT_HOLD;
                    end else if (src_tick) begin
                        counter_value <= count_inc;
                    end
                end else if (trig && !capture_mode_bit) begin
                    timer_irq <= 1'b1;
                    counter_value <= timer_pkg::COUNT_RESET;
                end else if (src_tick) begin
                    counter_value <= count_inc;
                end
            end else begin
                counter_value <= timer_pkg::COUNT_RESET;
                counting <= 1'b0;
            end
        end
    end

    // ========================================================
    // Capture register
    // ========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            capture_reg_b <= timer_pkg::CAPTURE_RESET;
        end else if (is_pw && counting && (opp || (trig && !capture_mode_bit))) begin
            capture_reg_b <= counter_value;
        end else if (auto_capture_bit && !is_pw && (src_tick || (is_evt && trig))) begin
            capture_reg_b <= counter_value;
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ext_idle_trig;
        is_ext && !stop_mode_entry && !counting && trig;
    endsequence

    sequence s_pw_single_opp;
        is_pw && capture_mode_bit && !stop_mode_entry && counting && opp;
    endsequence

    a_stop_clears_start: assert property (
        stop_mode_entry |=> start_control_field == timer_pkg::START_STOP && !counting)
        else $error("stop entry did not halt timer");

    a_irq_one_cycle: assert property (
        timer_irq |=> !timer_irq)
        else $error("interrupt longer than one cycle");

    a_ext_trig_start: assert property (
        s_ext_idle_trig |=> counting && counter_value == 16'h0000)
        else $error("trigger edge did not start counter");

    a_ext_opp_halt: assert property (
        is_ext && !stop_mode_entry && counting && trigger_stop_option && opp
        |=> !counting && counter_value == 16'h0000 && !timer_irq)
        else $error("opposite edge did not halt quietly");

    a_ext_match_irq: assert property (
        is_ext && !stop_mode_entry && counting && src_tick && match
        && !(trigger_stop_option && opp)
        |=> timer_irq && !counting && counter_value == 16'h0000)
        else $error("match did not halt and interrupt");

    a_ext_ignore_trig: assert property (
        is_ext && !stop_mode_entry && counting && !trigger_stop_option && trig && !src_tick
        |=> counting && $stable(counter_value))
        else $error("trigger edge disturbed running count");

    a_event_increment: assert property (
        is_evt && !stop_mode_entry && trig |=> counter_value == $past(counter_value) + 16'h0001)
        else $error("event edge did not increment");

    a_event_match: assert property (
        is_evt && !stop_mode_entry && !trig && opp && match
        |=> timer_irq && counter_value == 16'h0000)
        else $error("event match not handled at opposite edge");

    a_single_hold: assert property (
        s_pw_single_opp |=> counter_value == 16'h0001 && !counting
        && capture_reg_b == $past(counter_value) && timer_irq)
        else $error("single capture did not hold at one");

    a_auto_capture: assert property (
        auto_capture_bit && !is_pw && src_tick |=> capture_reg_b == $past(counter_value))
        else $error("auto capture missed a tick");

    a_lo_only_write: assert property (
        compare_wr_lo && !compare_wr_hi && !load_pending ##1 !compare_wr_hi
        |=> $stable(compare_reg_a))
        else $error("low byte write changed compare value");

endmodule : pin_triggered_timer

`default_nettype wire

// *** hdl/timer_pkg.sv ***
// Constants shared by the pin triggered timer and its input filter.
// Assumes a single 20 MHz clock that also serves as the fc reference.
package timer_pkg;

    // ========================================================
    // Clock and filter timing
    // ========================================================
    localparam int CLK_HZ = 20_000_000;
    localparam int FC_HZ = CLK_HZ;
    // Pin pulse widths in fc periods
    localparam int FILT_REJECT_FC = 4;
    localparam int FILT_ACCEPT_FC = 12;
    // Accept after a level has held for this many cycles
    localparam int FILT_REJECT_CYC = (FILT_REJECT_FC * CLK_HZ) / FC_HZ;
    localparam int FILT_ACCEPT_CYC = (FILT_ACCEPT_FC * CLK_HZ) / FC_HZ;
    localparam int FILT_CYCLES = (FILT_REJECT_CYC + FILT_ACCEPT_CYC) / 2;
    localparam logic [3:0] FILT_LAST = 4'(FILT_CYCLES - 1);

    // ========================================================
    // Prescaler
    // ========================================================
    localparam int PRESCALE_W = 11;
    localparam logic [10:0] PRE_DIV11 = 11'h7ff;
    localparam logic [10:0] PRE_DIV7 = 11'h07f;
    localparam logic [10:0] PRE_DIV3 = 11'h007;

    // ========================================================
    // Control field codes
    // ========================================================
    localparam logic [1:0] CLK_DIV11 = 2'h0;
    localparam logic [1:0] CLK_DIV7 = 2'h1;
    localparam logic [1:0] CLK_DIV3 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;

    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_WINDOW = 2'h1;
    localparam logic [1:0] MODE_PULSE = 2'h2;
    localparam logic [1:0] MODE_PULSEGEN = 2'h3;

    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_CMD = 2'h1;
    localparam logic [1:0] START_RISE = 2'h2;
    localparam logic [1:0] START_FALL = 2'h3;

    // ========================================================
    // Reset values and single capture hold value
    // ========================================================
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'hffff;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [15:0] COUNT_HOLD = 16'h0001;

endpackage : timer_pkg

// *** hdl/pin_input_filter.sv ***
// Synchroniser and noise filter for the timer input pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module pin_input_filter (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic bypass,
    output logic level,
    output logic rise,
    output logic fall
);

    logic sync_a;
    logic sync_b;
    logic [3:0] hold_cnt;
    logic accept;

    // ========================================================
    // Two flop synchroniser
    // ========================================================
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    // ========================================================
    // Level must hold before it is taken
    // ========================================================
    assign accept = (sync_b != level) && (bypass || hold_cnt == timer_pkg::FILT_LAST);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_cnt <= 4'h0;
        end else if (sync_b == level || accept) begin
            hold_cnt <= 4'h0;
        end else begin
            hold_cnt <= hold_cnt + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= accept && sync_b;
            fall <= accept && !sync_b;
            if (accept) begin
                level <= sync_b;
            end
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    a_filter_short_reject: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!bypass && $changed(level)) |-> $past(hold_cnt) == timer_pkg::FILT_LAST)
        else $error("filter passed a short pulse");

endmodule : pin_input_filter

`default_nettype wire

// *** bench/pulse_source.sv ***
// Pulse source model driving the timer input pin.
// Assumes the bench calls its tasks just after a ref_clk rising edge.
`timescale 1ns/100ps
`default_nettype none

module pulse_source (
    input wire logic ref_clk,
    output logic pin
);
    // ==========================================
    // Pin driving
    // ==========================================
    initial begin
        pin = 1'b0;
    end

    // Every level is held at least 12 cycles
    task automatic hold(input logic lvl, input int n);
        pin = lvl;
        repeat ((n < 12) ? 12 : n) @(posedge ref_clk);
        #5;
    endtask : hold

    // Short pulse, only when a noise test asks for it
    task automatic glitch(input int n);
        pin = ~pin;
        repeat (n) @(posedge ref_clk);
        #5;
        pin = ~pin;
    endtask : glitch
endmodule : pulse_source
`default_nettype wire

// *** bench/pin_triggered_timer_tb_top.sv ***
// Self-checking bench for the pin triggered timer.
// Assumes pulse_source drives the pin; the source clock is mostly clk/8.
`timescale 1ns/100ps
`default_nettype none

module pin_triggered_timer_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin;
    logic filter_off = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [1:0] clk_sel = 2'h2;
    logic stop_opt = 1'b0;
    logic acap = 1'b0;
    logic cmode = 1'b0;
    logic start_wr = 1'b0;
    logic [1:0] start_data = 2'h0;
    logic stop_entry = 1'b0;
    logic wr_lo = 1'b0;
    logic wr_hi = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [1:0] start_field;
    logic [15:0] cmp_a;
    logic [15:0] cap_b;
    logic [15:0] count;
    logic counting;
    logic irq;
    logic irq_prev = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    int irq_n = 0;
    int cycles = 0;
    int base;

    always #25 ref_clk = ~ref_clk;

    pulse_source src (.ref_clk(ref_clk), .pin(pin));

    pin_triggered_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .timer_input_pin(pin),
        .filter_off(filter_off), .operating_mode_select(mode), .source_clock_select(clk_sel),
        .trigger_stop_option(stop_opt), .auto_capture_bit(acap), .capture_mode_bit(cmode),
        .start_wr(start_wr), .start_wr_data(start_data), .stop_mode_entry(stop_entry),
        .compare_wr_lo(wr_lo), .compare_wr_hi(wr_hi), .compare_wr_data(wr_data),
        .start_control_field(start_field), .compare_reg_a(cmp_a), .capture_reg_b(cap_b),
        .counter_value(count), .counting(counting), .timer_irq(irq));

    // ==========================================
    // Tasks
    // ==========================================
    task automatic stop_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        check({15'h0, (v >= lo) && (v <= hi)}, 16'h0001);
    endtask : check_rng

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask : cyc

    task automatic start(input logic [1:0] v);
        start_data = v;
        start_wr = 1'b1;
        cyc(1);
        start_wr = 1'b0;
        cyc(1);
    endtask : start

    task automatic set_cmp(input logic [15:0] v);
        wr_data = v[7:0];
        wr_lo = 1'b1;
        cyc(1);
        wr_lo = 1'b0;
        wr_data = v[15:8];
        wr_hi = 1'b1;
        cyc(1);
        wr_hi = 1'b0;
        cyc(20);
        check(cmp_a, v);
    endtask : set_cmp

    task automatic check_run(input logic exp_run, input int exp_irq);
        check({15'h0, counting}, {15'h0, exp_run});
        check(16'(irq_n), 16'(exp_irq));
    endtask : check_run

    // ==========================================
    // Monitor and timeout
    // ==========================================
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        irq_prev <= irq;
        if (irq === 1'b1) begin
            irq_n <= irq_n + 1;
        end
        if (irq === 1'b1 && irq_prev === 1'b1) begin
            check(16'h0, 16'h0001);
        end
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // ==========================================
    // Scenarios
    // ==========================================
    initial begin
        cyc(4);
        rst_n = 1'b1;
        cyc(1);
        check({start_field, counting, irq, 12'h000}, 16'h0000);
        check(cmp_a, 16'hffff);
        check(cap_b | count, 16'h0000);
        wr_data = 8'h12;
        wr_lo = 1'b1;
        cyc(1);
        wr_lo = 1'b0;
        cyc(20);
        check(cmp_a, 16'hffff);
        // Trigger timer, stop option set
        set_cmp(16'h0003);
        stop_opt = 1'b1;
        start(2'h2);
        cyc(30);
        check_run(1'b0, 0);
        src.hold(1'b1, 20);
        check_run(1'b1, 0);
        src.hold(1'b1, 60);
        check_run(1'b0, 1);
        check(count, 16'h0000);
        src.hold(1'b0, 20);
        set_cmp(16'h000a);
        src.hold(1'b1, 30);
        src.hold(1'b0, 30);
        check_run(1'b0, 1);
        check(count, 16'h0000);
        src.hold(1'b1, 20);
        check_run(1'b1, 1);
        check_rng(count, 16'h0000, 16'h0002);
        src.hold(1'b1, 120);
        check_run(1'b0, 2);
        src.hold(1'b0, 20);
        // Trigger timer, stop option clear
        start(2'h0);
        stop_opt = 1'b0;
        start(2'h2);
        src.hold(1'b1, 20);
        src.hold(1'b0, 20);
        check_run(1'b1, 2);
        src.hold(1'b1, 100);
        check_run(1'b0, 3);
        src.hold(1'b0, 20);
        // Noise filter
        src.glitch(5);
        cyc(20);
        check_run(1'b0, 3);
        filter_off = 1'b1;
        src.glitch(5);
        cyc(20);
        check_run(1'b1, 3);
        filter_off = 1'b0;
        // Event counter
        start(2'h0);
        set_cmp(16'h0003);
        clk_sel = 2'h3;
        start(2'h2);
        repeat (2) begin
            src.hold(1'b1, 16);
            src.hold(1'b0, 16);
        end
        check(count, 16'h0002);
        src.hold(1'b1, 16);
        check(count, 16'h0003);
        check_run(1'b1, 3);
        src.hold(1'b0, 20);
        check_run(1'b1, 4);
        check(count, 16'h0000);
        // Auto capture in command timer
        start(2'h0);
        clk_sel = 2'h2;
        set_cmp(16'hffff);
        acap = 1'b1;
        start(2'h1);
        cyc(50);
        check_rng(cap_b, count - 16'h0001, count);
        check_rng(cap_b, 16'h0005, 16'h0006);
        start(2'h0);
        clk_sel = 2'h1;
        start(2'h1);
        cyc(300);
        check_rng(cap_b, 16'h0001, 16'h0002);
        start(2'h0);
        clk_sel = 2'h0;
        start(2'h1);
        cyc(2100);
        check_rng(count, 16'h0001, 16'h0002);
        start(2'h0);
        clk_sel = 2'h2;
        acap = 1'b0;
        // Window, both polarities
        mode = 2'h1;
        start(2'h2);
        cyc(40);
        check(count, 16'h0000);
        src.hold(1'b1, 80);
        check_rng(count, 16'h0008, 16'h000b);
        src.hold(1'b0, 40);
        check_rng(count, 16'h0008, 16'h000b);
        start(2'h0);
        start(2'h3);
        cyc(40);
        check_rng(count, 16'h0005, 16'h0006);
        // Pulse width, single edge
        start(2'h0);
        mode = 2'h2;
        cmode = 1'b1;
        base = irq_n;
        start(2'h2);
        repeat (2) begin
            src.hold(1'b1, 80);
            src.hold(1'b0, 30);
            check_rng(cap_b, 16'h0009, 16'h000c);
            check(count, 16'h0001);
            base++;
            check_run(1'b0, base);
        end
        // Pulse width, double edge, then stop power mode
        start(2'h0);
        cmode = 1'b0;
        start(2'h2);
        src.hold(1'b1, 80);
        src.hold(1'b0, 20);
        check_rng(cap_b, 16'h0009, 16'h000b);
        check_run(1'b1, base + 1);
        src.hold(1'b0, 60);
        src.hold(1'b1, 20);
        check_rng(cap_b, 16'h0013, 16'h0015);
        check_run(1'b1, base + 2);
        check_rng(count, 16'h0000, 16'h0002);
        stop_entry = 1'b1;
        cyc(1);
        stop_entry = 1'b0;
        cyc(2);
        check({14'h0, start_field}, 16'h0000);
        check_run(1'b0, base + 2);
        stop_test();
    end
endmodule : pin_triggered_timer_tb_top
`default_nettype wire
